// ===== src/geif_pkg.sv
package geif_pkg;
	// pin count of the port
	localparam int NUM_PINS = 8;
	// reset values of the per-pin registers
	localparam logic [7:0] FALL_EN_RESET   = 8'h00;
	localparam logic [7:0] RISE_EN_RESET   = 8'h00;
	localparam logic [7:0] FILTER_EN_RESET = 8'hff;
	localparam logic [7:0] IRQ_EN_RESET    = 8'h00;
	localparam logic [7:0] DIR_RESET       = 8'hff;
	// filter timing
	localparam int CLK_FREQ_MHZ       = 50;
	localparam int FILTER_ACCEPT_NS   = 1075;
	localparam int FILTER_REJECT_NS   = 225;
	localparam int FILTER_REJECT_CYC  = (FILTER_REJECT_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int FILTER_ACCEPT_CYC  = (FILTER_ACCEPT_NS * CLK_FREQ_MHZ) / 1000;
	// acceptance threshold, placed midway inside the allowed band
	localparam int FILTER_THRESH_CYC  = (FILTER_REJECT_CYC + FILTER_ACCEPT_CYC) / 2;
	// cycles after reset before edges count: two sync flops, a full filter run, the edge flop
	localparam int SETTLE_CYC         = FILTER_THRESH_CYC + 4;
	localparam int FILTER_CNT_W       = 6;
endpackage

// ===== src/geif_pin_filter.sv
`timescale 1ns/10ps
// per-pin glitch filter: output follows the input once it has held for thresh_cyc cycles
module geif_pin_filter
	import geif_pkg::*;
#(
	parameter int THRESH_CYC = FILTER_THRESH_CYC
) (
	input  wire logic clk_in,
	input  wire logic srst_in,
	input  wire logic raw_in,
	input  wire logic filter_en_in,
	output logic      level_out
);
	logic [FILTER_CNT_W-1:0] stable_cnt;
	localparam logic [FILTER_CNT_W-1:0] THRESH = FILTER_CNT_W'(THRESH_CYC);

	// count how long raw has differed from the accepted level
	always_ff @(posedge clk_in) begin
		if (srst_in || raw_in == level_out || !filter_en_in) begin
			stable_cnt <= '0;
		end else begin
			stable_cnt <= stable_cnt + 1'b1;
		end
	end

	// accept after the threshold; short pulses reset the count and vanish
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			level_out <= 1'b0;
		end else if (!filter_en_in) begin
			level_out <= raw_in;
		end else if (raw_in != level_out && stable_cnt >= THRESH - 1'b1) begin
			level_out <= raw_in;
		end
	end
endmodule // geif_pin_filter

// ===== src/geif_gpio_edge_irq_filter.sv
`timescale 1ns/10ps
module geif_gpio_edge_irq_filter
	import geif_pkg::*;
#(
	parameter int WIDTH = NUM_PINS
) (
	input  wire logic             clk_in,
	input  wire logic             srst_in,
	input  wire logic [WIDTH-1:0] pin_in,
	input  wire logic             wr_en_in,
	input  wire logic [WIDTH-1:0] falling_edge_irq_enable_in,
	input  wire logic [WIDTH-1:0] rising_edge_irq_enable_in,
	input  wire logic [WIDTH-1:0] input_glitch_filter_enable_in,
	input  wire logic [WIDTH-1:0] pin_irq_enable_in,
	input  wire logic [WIDTH-1:0] pin_direction_config_in,
	input  wire logic             state_rd_in,
	output logic      [WIDTH-1:0] falling_edge_irq_enable_out,
	output logic      [WIDTH-1:0] rising_edge_irq_enable_out,
	output logic      [WIDTH-1:0] input_glitch_filter_enable_out,
	output logic      [WIDTH-1:0] pin_irq_enable_out,
	output logic      [WIDTH-1:0] pin_direction_config_out,
	output logic      [WIDTH-1:0] pin_state_register_out,
	output logic      [WIDTH-1:0] irq_status_out,
	output logic                  irq_n_out
);
	logic [WIDTH-1:0] sync_a;
	logic [WIDTH-1:0] sync_b;
	logic [WIDTH-1:0] filt;
	logic [WIDTH-1:0] filt_d;
	logic [WIDTH-1:0] last_read;
	logic [WIDTH-1:0] next_status;
	logic [WIDTH-1:0] rise_ev;
	logic [WIDTH-1:0] fall_ev;
	logic [WIDTH-1:0] both_mode;
	logic [WIDTH-1:0] qualify;
	logic [FILTER_CNT_W-1:0] settle_cnt;
	logic                    settled;
	localparam logic [FILTER_CNT_W-1:0] SETTLE_LAST = FILTER_CNT_W'(SETTLE_CYC - 1);

	// one edge kind passes where its own enable or both-edge mode selects it;
	// shared by the rising and the falling path so both decode alike
	function automatic logic [WIDTH-1:0] edge_pass(
		input logic [WIDTH-1:0] ev,
		input logic [WIDTH-1:0] en,
		input logic [WIDTH-1:0] both
	);
		return ev & (en | both);
	endfunction

	// latency from pin to flag: two sync flops, the filter, then the flag flop;
	// with the filter on, the filter alone adds its threshold in cycles

	// two-flop synchroniser for asynchronous pins
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= pin_in;
			sync_b <= sync_a;
		end
	end

	// register file, all written by one strobe; bit index equals pin number
	// no address is decoded, so software must present every word on each write

	// falling-edge enables
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			falling_edge_irq_enable_out <= FALL_EN_RESET;
		end else if (wr_en_in) begin
			falling_edge_irq_enable_out <= falling_edge_irq_enable_in;
		end
	end

	// rising-edge enables
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rising_edge_irq_enable_out <= RISE_EN_RESET;
		end else if (wr_en_in) begin
			rising_edge_irq_enable_out <= rising_edge_irq_enable_in;
		end
	end

	// glitch filter enables, all on out of reset
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			input_glitch_filter_enable_out <= FILTER_EN_RESET;
		end else if (wr_en_in) begin
			input_glitch_filter_enable_out <= input_glitch_filter_enable_in;
		end
	end

	// per-pin interrupt enables, all off out of reset
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pin_irq_enable_out <= IRQ_EN_RESET;
		end else if (wr_en_in) begin
			pin_irq_enable_out <= pin_irq_enable_in;
		end
	end

	// direction: one means input; outputs never interrupt
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pin_direction_config_out <= DIR_RESET;
		end else if (wr_en_in) begin
			pin_direction_config_out <= pin_direction_config_in;
		end
	end

	// settle counter: sync flops and filters wake at zero while idle pins sit high,
	// so without this mask the first real level would look like a rising edge
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			settle_cnt <= '0;
		end else if (!settled) begin
			settle_cnt <= settle_cnt + 1'b1;
		end
	end

	// settled stays up until the next reset
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			settled <= 1'b0;
		end else if (settle_cnt == SETTLE_LAST) begin
			settled <= 1'b1;
		end
	end

	// one filter per pin, each with its own enable
	for (genvar i = 0; i < WIDTH; i++) begin : g_filt
		geif_pin_filter u_filt (
			.clk_in       (clk_in),
			.srst_in      (srst_in),
			.raw_in       (sync_b[i]),
			.filter_en_in (input_glitch_filter_enable_out[i]),
			.level_out    (filt[i])
		);
	end

	// delayed filtered level for edge detection
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			filt_d <= '0;
		end else begin
			filt_d <= filt;
		end
	end

	// edge qualification per pin
	always_comb begin
		rise_ev   = filt & ~filt_d;
		fall_ev   = ~filt & filt_d;
		both_mode = ~(rising_edge_irq_enable_out ^ falling_edge_irq_enable_out);
		qualify   = (edge_pass(rise_ev, rising_edge_irq_enable_out, both_mode)
			| edge_pass(fall_ev, falling_edge_irq_enable_out, both_mode))
			& pin_irq_enable_out & pin_direction_config_out
			& {WIDTH{settled}};
	end

	// pending flags: a new edge wins over a clear in the same cycle
	always_comb begin
		next_status = irq_status_out;
		if (state_rd_in) begin
			next_status = '0;
		end
		// both-edge mode: returning to last read level withdraws the request
		next_status = next_status & ~(both_mode & ~(filt ^ last_read));
		next_status = next_status | qualify;
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			irq_status_out <= '0;
		end else begin
			irq_status_out <= next_status;
		end
	end

	// level captured at each state read
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			last_read <= '0;
		end else if (state_rd_in) begin
			last_read <= filt;
		end
	end

	// state register view: unfiltered synchronised pins, one flop more
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pin_state_register_out <= '0;
		end else begin
			pin_state_register_out <= sync_b;
		end
	end

	// active-low interrupt from the same next value as the flags, so both move together
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			irq_n_out <= 1'b1;
		end else begin
			irq_n_out <= ~|next_status;
		end
	end
endmodule // geif_gpio_edge_irq_filter

// ===== verif/geif_assertions.sv
`timescale 1ns/10ps
// sees only top ports; edge, filter and clear checks
module geif_chk (
	input wire logic       clk_in,
	input wire logic       srst_in,
	input wire logic       wr_en_in,
	input wire logic       state_rd_in,
	input wire logic [7:0] falling_edge_irq_enable_in,
	input wire logic [7:0] falling_edge_irq_enable_out,
	input wire logic [7:0] rising_edge_irq_enable_out,
	input wire logic [7:0] input_glitch_filter_enable_out,
	input wire logic [7:0] pin_irq_enable_out,
	input wire logic [7:0] pin_direction_config_out,
	input wire logic [7:0] pin_state_register_out,
	input wire logic [7:0] irq_status_out,
	input wire logic       irq_n_out
);
	logic [7:0] old;
	wire  [7:0] fe = falling_edge_irq_enable_out, re = rising_edge_irq_enable_out, ps = pin_state_register_out;
	wire  [7:0] st = irq_status_out, nf = st & ~old, fo = fe & ~re & ~input_glitch_filter_enable_out;
	// last flags, so freshly raised ones show
	always_ff @(posedge clk_in) begin
		old <= st;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	sequence s_fall0; $fell(ps[0]) && fo[0] && pin_irq_enable_out[0] && pin_direction_config_out[0]; endsequence
	chk_irq_line: assert property (irq_n_out == ~|st) else $error("irq line wrong");
	chk_gate_pins: assert property ((nf & ~(pin_irq_enable_out & pin_direction_config_out)) == 8'h00)
		else $error("flag on gated pin");
	chk_fall_only: assert property ((nf & fo & ps) == 8'h00) else $error("rise flagged");
	chk_glitch_gone: assert property ((nf & input_glitch_filter_enable_out & (ps ^ $past(ps, 10))) == 8'h00)
		else $error("short pulse flagged");
	chk_fast_pin: assert property (s_fall0 |-> ##[0:3] st[0]) else $error("late flag");
	chk_read_clear: assert property (|(old & ~st & (fe ^ re)) |-> $past(state_rd_in))
		else $error("flag lost");
	chk_cfg_load: assert property (wr_en_in |=> fe == $past(falling_edge_irq_enable_in)) else $error("no load");
	chk_filt_hold: assert property (!wr_en_in |=> $stable(input_glitch_filter_enable_out))
		else $error("filter moved");
endmodule // geif_chk

bind geif_gpio_edge_irq_filter geif_chk i_chk (.clk_in, .srst_in, .wr_en_in, .state_rd_in, .falling_edge_irq_enable_in,
	.falling_edge_irq_enable_out, .rising_edge_irq_enable_out, .input_glitch_filter_enable_out, .pin_irq_enable_out,
	.pin_direction_config_out, .pin_state_register_out, .irq_status_out, .irq_n_out);

// ===== verif/geif_pin_source.sv
`timescale 1ns/10ps
// external pin drivers; levels idle high
module geif_pin_source (
	input  wire logic       clk_in,
	output logic      [7:0] pin_out
);
	initial pin_out = 8'hff;
	// toggles one pin; caller sets pulse length
	task automatic flip(input int i);
		pin_out[i] = ~pin_out[i];
	endtask
endmodule // geif_pin_source

// ===== verif/test_gpio_edge_irq_filter.sv
`timescale 1ns/10ps
// config and reads driven here; pins from the source model
module test_gpio_edge_irq_filter;
	logic       clk_in = 0, srst_in = 1, wr = 0, rdp = 0, irq_n;
	logic [7:0] f, r, g, e, d, pins, fo, go, fl, ro, ps, q[$];
	int         mismatches = 0, samples_checked = 0;
	always #10 clk_in = ~clk_in;
	geif_pin_source i_src (.clk_in, .pin_out(pins));
	geif_gpio_edge_irq_filter i_dut (.clk_in, .srst_in, .pin_in(pins), .wr_en_in(wr), .falling_edge_irq_enable_in(f),
		.rising_edge_irq_enable_in(r), .input_glitch_filter_enable_in(g), .pin_irq_enable_in(e),
		.pin_direction_config_in(d), .state_rd_in(rdp), .falling_edge_irq_enable_out(fo),
		.rising_edge_irq_enable_out(ro), .input_glitch_filter_enable_out(go), .pin_irq_enable_out(),
		.pin_direction_config_out(), .pin_state_register_out(ps), .irq_status_out(fl), .irq_n_out(irq_n));
	task check(string n, logic [7:0] s, logic [7:0] x);
		samples_checked++;
		if (s !== x) begin
			mismatches++;
			$display("MISMATCH %s exp %h seen %h", n, x, s);
		end
	endtask
	task tick(int n);
		repeat (n) @(posedge clk_in);
		#2;
	endtask
	task cfg(logic [7:0] ff, rr, gg, ee, dd);
		{f, r, g, e, d, wr} = {ff, rr, gg, ee, dd, 1'b1};
		tick(1);
		wr = 0;
		tick(1);
	endtask
	task rd;
		rdp = 1;
		tick(1);
		rdp = 0;
		tick(1);
	endtask
	task pulse(int i, int w);
		i_src.flip(i);
		tick(w);
		i_src.flip(i);
	endtask
	task stop_test;
		if (mismatches == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// oldest expectation is matched whenever the line drops
	always @(negedge irq_n) begin
		#1;
		check("flags", fl, q.size() ? q.pop_front() : 8'h00);
	end
	// hang guard, far beyond the few hundred cycles needed
	initial begin
		#100us;
		mismatches++;
		stop_test;
	end
	initial begin
		{f, r, g, e, d} = '0;
		void'($urandom(37));
		tick(4);
		srst_in = 0;
		check("filter rst", go, 8'hff);
		tick(40);
		check("pin state", ps, 8'hff);
		// random gating, unfiltered falls on every pin
		cfg(8'hff, 8'h00, 8'h00, 8'($urandom), 8'($urandom));
		for (int i = 0; i < 8; i++) begin
			if (e[i] & d[i]) q.push_back(8'h01 << i);
			pulse(i, 4 + $urandom % 8);
			tick(6);
			rd;
		end
		// pin 3 unfiltered, pin 4 filtered: glitch dropped, long pulse kept
		cfg(8'hff, 8'h00, 8'hf7, 8'hff, 8'hff);
		check("filter", go, 8'hf7);
		q.push_back(8'h08);
		pulse(3, 3);
		tick(8);
		rd;
		pulse(4, 10);
		tick(60);
		q.push_back(8'h10);
		pulse(4, 56);
		tick(40);
		rd;
		// all four edge selections on pin 0, read taken while low
		for (int m = 0; m < 4; m++) begin
			cfg({7'h00, m[0]}, {7'h00, m[1]}, 8'h00, 8'hff, 8'hff);
			check("rise en", ro, {7'h00, m[1]});
			rd;
			if (m != 2) q.push_back(8'h01);
			i_src.flip(0);
			tick(8);
			check("pin state", ps, 8'hfe);
			rd;
			if (m != 1) q.push_back(8'h01);
			i_src.flip(0);
			tick(8);
			rd;
		end
		check("left", 8'(q.size()), 8'h00);
		stop_test;
	end
endmodule // test_gpio_edge_irq_filter
